// [bench/ncsr_panel.sv]
// Site status panel model watching the normally-closed contact
`timescale 1ns/100ps
module ncsr_panel (
  input wire logic i_contact_open,
  output logic o_lamp_on
);
  // Loop current flows only through a closed contact
  assign o_lamp_on = !i_contact_open;
endmodule

// [bench/ncsr_relay_checker.sv]
// Concurrent checks on the status relay decision logic ports
`timescale 1ns/100ps
`include "ncsr_regs.svh"
module ncsr_relay_checker #(
  parameter int VAL_W = 16,
  parameter int ADDR_W = 8
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire ncsr_pkg::ncsr_status_t i_status,
  input wire logic [VAL_W-1:0] i_temp_value,
  input wire logic [VAL_W-1:0] i_input_value,
  input wire logic o_contact_open,
  input wire logic o_tripped
);
  logic [3:0] md_q;
  logic [5:0] s1_q;
  logic [5:0] s2_q;
  logic [VAL_W-1:0] sp_q;
  logic [VAL_W-1:0] db_q;
  logic [VAL_W-1:0] val;
  logic [VAL_W-1:0] thr;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // Shadow of mode, setpoint, deadband and the two-flop status sync
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      md_q <= 4'h0;
      sp_q <= `NCSR_RST_SETPOINT;
      db_q <= `NCSR_RST_DEADBAND;
      s1_q <= 6'h00;
      s2_q <= 6'h00;
    end else begin
      s1_q <= i_status;
      s2_q <= s1_q;
      if (i_wr && i_addr == `NCSR_OFS_CTRL) md_q <= (i_wdata[3:0] > 4'h8) ? 4'h0 : i_wdata[3:0];
      if (i_wr && i_addr == `NCSR_OFS_SETPOINT) sp_q <= i_wdata[VAL_W-1:0];
      if (i_wr && i_addr == `NCSR_OFS_DEADBAND) db_q <= i_wdata[VAL_W-1:0];
    end
  end
  // Selected value and saturating release threshold
  assign val = (md_q == 4'h6) ? i_temp_value : i_input_value;
  assign thr = (sp_q > db_q) ? sp_q - db_q : '0;
  chk_disabled_closed: assert property (
    md_q == 4'h0 |=> !o_contact_open) else $error("disabled mode contact open");
  chk_started_run: assert property (
    md_q == 4'h1 |=> o_contact_open == $past(s2_q[0])) else $error("started mode mismatch");
  chk_hot_alarm: assert property (
    md_q == 4'h2 |=> o_contact_open == $past(s2_q[1])) else $error("high temp mode mismatch");
  chk_alert_free: assert property (
    md_q == 4'h3 |=> o_contact_open == !$past(s2_q[2])) else $error("no alert mode mismatch");
  chk_any_proc: assert property (
    md_q == 4'h4 |=> o_contact_open == $past(s2_q[3])) else $error("appliance proc mismatch");
  chk_local_proc: assert property (
    md_q == 4'h5 |=> o_contact_open == $past(s2_q[4])) else $error("local proc mismatch");
  chk_purge_open: assert property (
    md_q == 4'h8 |=> o_contact_open == $past(s2_q[5])) else $error("purge mode mismatch");
  chk_temp_trip: assert property (
    md_q == 4'h6 && $stable(md_q) && i_temp_value > sp_q |=> o_tripped && o_contact_open)
    else $error("temperature trip missed");
  chk_input_trip: assert property (
    md_q == 4'h7 && $stable(md_q) && i_input_value > sp_q |=> o_tripped && o_contact_open)
    else $error("input trip missed");
  chk_trip_release: assert property (
    md_q inside {4'h6, 4'h7} && $stable(md_q) && val < thr |=> !o_tripped && !o_contact_open)
    else $error("trip not released");
  chk_trip_hold: assert property (
    md_q inside {4'h6, 4'h7} && $stable(md_q) && o_tripped && val >= thr |=> o_tripped)
    else $error("trip released early");
  // Main scenarios reached
  cover property (md_q == 4'h6 ##1 o_tripped);
  cover property (md_q == 4'h7 && o_tripped ##1 !o_tripped);
  cover property (md_q == 4'h3 && o_contact_open);
endmodule

// [bench/test_ncsr_relay.sv]
// Self-checking bench for the status relay decision logic
`timescale 1ns/100ps
`include "ncsr_regs.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module test_ncsr_relay;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  ncsr_pkg::ncsr_status_t i_status = '0;
  logic [15:0] i_temp_value = 16'h0;
  logic [15:0] i_input_value = 16'h0;
  logic o_contact_open;
  logic o_tripped;
  logic lamp_on;
  logic [31:0] rv;
  logic [3:0] modes [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8};
  logic [15:0] tv [6] = '{16'h64, 16'h65, 16'h5b, 16'h5a, 16'h59, 16'h64};
  logic et [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  always #20 i_clk = ~i_clk;
  ncsr_relay dut (.i_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_status,
    .i_temp_value, .i_input_value, .o_contact_open, .o_tripped);
  ncsr_panel panel (.i_contact_open(o_contact_open), .o_lamp_on(lamp_on));
  // Expected contact state for the level modes
  function automatic logic exp_open(input logic [3:0] m, input logic [5:0] s);
    case (m)
      4'h1: return s[0];
      4'h2: return s[1];
      4'h3: return !s[2];
      4'h4: return s[3];
      4'h5: return s[4];
      4'h8: return s[5];
      default: return 1'b0;
    endcase
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
    @(posedge i_clk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    rd(`NCSR_OFS_SETPOINT, rv);
    `CHK(rv, 32'hffff)
    rd(8'h14, rv);
    `CHK(rv, 32'h0)
    wr(`NCSR_OFS_CTRL, 32'h9);
    rd(`NCSR_OFS_CTRL, rv);
    `CHK(rv, 32'h0)
    // Every level mode against every single status bit, none and all
    foreach (modes[m]) begin
      wr(`NCSR_OFS_CTRL, {28'h0, modes[m]});
      for (int p = 0; p < 8; p++) begin
        i_status <= (p == 7) ? 6'h3f : 6'h01 << p;
        repeat (4) @(posedge i_clk);
        #1 `CHK(lamp_on, !exp_open(modes[m], i_status))
      end
    end
    // Setpoint trip with hysteresis, other value held high
    wr(`NCSR_OFS_SETPOINT, 32'h64);
    wr(`NCSR_OFS_DEADBAND, 32'ha);
    for (int m = 6; m < 8; m++) begin
      wr(`NCSR_OFS_CTRL, 32'(m));
      foreach (tv[k]) begin
        i_temp_value <= (m == 6) ? tv[k] : 16'hffff;
        i_input_value <= (m == 7) ? tv[k] : 16'hffff;
        repeat (2) @(posedge i_clk);
        #1 `CHK({o_tripped, lamp_on}, {et[k], !et[k]})
      end
    end
    // Status, value and deadband readback while tripped in input mode
    i_input_value <= 16'h70;
    repeat (2) @(posedge i_clk);
    rd(`NCSR_OFS_STATUS, rv);
    `CHK(rv, 32'hff)
    #1 `CHK(o_rdata, 32'h0)
    rd(`NCSR_OFS_VALUE, rv);
    `CHK(rv, 32'h70)
    rd(`NCSR_OFS_DEADBAND, rv);
    `CHK(rv, 32'ha)
    // Reset in mid-run closes the contact and restores disabled mode
    i_nrst <= 1'b0;
    @(posedge i_clk);
    #1 `CHK({o_tripped, o_contact_open}, 2'b00)
    @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    rd(`NCSR_OFS_CTRL, rv);
    `CHK(rv, 32'h0)
    rd(`NCSR_OFS_SETPOINT, rv);
    `CHK(rv, 32'hffff)
    finish_test();
  end
endmodule
bind ncsr_relay ncsr_relay_checker #(.VAL_W(VAL_W), .ADDR_W(ADDR_W)) chk (.i_clk, .i_nrst,
  .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_status, .i_temp_value, .i_input_value,
  .o_contact_open, .o_tripped);

// [design/ncsr_relay.sv]
// Normally-closed status relay decision logic with register port
`timescale 1ns/100ps
`include "ncsr_regs.svh"

// Functional notes
// - Started mode opens the contact while any appliance controller runs.
// - High temperature mode opens the contact while any high temperature alarm exists.
// - No-alert mode opens the contact while no controller has alerts.
// - No-alert mode closes the contact whenever any controller has alerts.
// - Appliance process mode opens while any controller is in process control.
// - Controller process mode opens only while the connected controller is in it.
// - Temperature trip mode opens when the temperature value rises above setpoint.
// - Input trip mode opens when the selected input exceeds its setpoint.
// - Trip clears once value falls below setpoint minus deadband, or when the mode changes.
// - Purge mode opens the contact while the connected controller is purging.
module ncsr_relay #(
  parameter int VAL_W = 16,
  parameter int ADDR_W = 8
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire ncsr_pkg::ncsr_status_t i_status,
  input wire logic [VAL_W-1:0] i_temp_value,
  input wire logic [VAL_W-1:0] i_input_value,
  output logic o_contact_open,
  output logic o_tripped
);

  // Saturating difference, floor at zero
  function automatic logic [VAL_W-1:0] sat_sub(input logic [VAL_W-1:0] a,
                                               input logic [VAL_W-1:0] b);
    if (a > b) begin
      sat_sub = a - b;
    end else begin
      sat_sub = '0;
    end
  endfunction

  // True for the two setpoint comparison modes
  function automatic logic is_trip_mode(input ncsr_pkg::ncsr_mode_t m);
    is_trip_mode = (m == ncsr_pkg::NCSR_MODE_TEMP_TRIP) ||
                   (m == ncsr_pkg::NCSR_MODE_INPUT_TRIP);
  endfunction

  // Address match for one register
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction

  ncsr_pkg::ncsr_mode_t mode_q;
  ncsr_pkg::ncsr_mode_t mode_prev_q;
  logic [VAL_W-1:0] setpoint_q;
  logic [VAL_W-1:0] deadband_q;
  ncsr_pkg::ncsr_status_t stat_meta_q;
  ncsr_pkg::ncsr_status_t stat_q;
  ncsr_pkg::ncsr_trip_t trip_q;
  ncsr_pkg::ncsr_trip_t trip_d;
  logic [VAL_W-1:0] value;
  logic [VAL_W-1:0] release_lvl;
  logic open_q;
  logic open_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Status pins cross in through two flops
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      stat_meta_q <= '0;
      stat_q <= '0;
    end else begin
      stat_meta_q <= i_status;
      stat_q <= stat_meta_q;
    end
  end

  // Mode register; unknown codes fall back to disabled
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_q <= ncsr_pkg::ncsr_mode_t'(`NCSR_RST_MODE);
    end else if (i_wr && hit(i_addr, `NCSR_OFS_CTRL)) begin
      if (i_wdata[`NCSR_CTRL_MODE_MSB:`NCSR_CTRL_MODE_LSB] <= 4'h8) begin
        mode_q <= ncsr_pkg::ncsr_mode_t'(i_wdata[`NCSR_CTRL_MODE_MSB:`NCSR_CTRL_MODE_LSB]);
      end else begin
        mode_q <= ncsr_pkg::NCSR_MODE_DISABLED;
      end
    end
  end

  // Setpoint and deadband registers
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      setpoint_q <= `NCSR_RST_SETPOINT;
      deadband_q <= `NCSR_RST_DEADBAND;
    end else if (i_wr) begin
      if (hit(i_addr, `NCSR_OFS_SETPOINT)) begin
        setpoint_q <= i_wdata[VAL_W-1:0];
      end
      if (hit(i_addr, `NCSR_OFS_DEADBAND)) begin
        deadband_q <= i_wdata[VAL_W-1:0];
      end
    end
  end

  // Selected analogue value and release threshold
  always_comb begin
    if (mode_q == ncsr_pkg::NCSR_MODE_TEMP_TRIP) begin
      value = i_temp_value;
    end else begin
      value = i_input_value;
    end
    release_lvl = sat_sub(setpoint_q, deadband_q);
  end

  // Hysteresis: set above setpoint, clear below setpoint minus deadband
  always_comb begin
    trip_d = trip_q;
    if (!is_trip_mode(mode_q) || (mode_q != mode_prev_q)) begin
      trip_d = ncsr_pkg::NCSR_TRIP_IDLE;
    end else begin
      case (trip_q)
        ncsr_pkg::NCSR_TRIP_IDLE: begin
          if (value > setpoint_q) begin
            trip_d = ncsr_pkg::NCSR_TRIP_ACTIVE;
          end
        end
        ncsr_pkg::NCSR_TRIP_ACTIVE: begin
          if (value < release_lvl) begin
            trip_d = ncsr_pkg::NCSR_TRIP_IDLE;
          end
        end
        default: begin
          trip_d = ncsr_pkg::NCSR_TRIP_IDLE;
        end
      endcase
    end
  end

  // Trip state and last mode, so a mode change restarts the comparison
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      trip_q <= ncsr_pkg::NCSR_TRIP_IDLE;
      mode_prev_q <= ncsr_pkg::NCSR_MODE_DISABLED;
    end else begin
      trip_q <= trip_d;
      mode_prev_q <= mode_q;
    end
  end

  // Contact decision per mode; high means contact open
  always_comb begin
    case (mode_q)
      ncsr_pkg::NCSR_MODE_DISABLED: open_d = 1'b0;
      ncsr_pkg::NCSR_MODE_STARTED: open_d = stat_q.running_any;
      ncsr_pkg::NCSR_MODE_HIGH_TEMP: open_d = stat_q.high_temp_any;
      ncsr_pkg::NCSR_MODE_NO_ALERT: open_d = !stat_q.alerts_any;
      ncsr_pkg::NCSR_MODE_APPL_PROC: open_d = stat_q.proc_ctrl_any;
      ncsr_pkg::NCSR_MODE_CTRL_PROC: open_d = stat_q.proc_ctrl_local;
      ncsr_pkg::NCSR_MODE_TEMP_TRIP,
      ncsr_pkg::NCSR_MODE_INPUT_TRIP: open_d = (trip_d == ncsr_pkg::NCSR_TRIP_ACTIVE);
      ncsr_pkg::NCSR_MODE_PURGE: open_d = stat_q.purging_local;
      default: open_d = 1'b0;
    endcase
  end

  // Registered contact drive, closed from reset
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      open_q <= 1'b0;
    end else begin
      open_q <= open_d;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = '0;
    if (i_rd) begin
      if (hit(i_addr, `NCSR_OFS_CTRL)) begin
        rdata_d[`NCSR_CTRL_MODE_MSB:`NCSR_CTRL_MODE_LSB] = mode_q;
      end else if (hit(i_addr, `NCSR_OFS_SETPOINT)) begin
        rdata_d[VAL_W-1:0] = setpoint_q;
      end else if (hit(i_addr, `NCSR_OFS_DEADBAND)) begin
        rdata_d[VAL_W-1:0] = deadband_q;
      end else if (hit(i_addr, `NCSR_OFS_STATUS)) begin
        rdata_d[`NCSR_STAT_OPEN_BIT] = open_q;
        rdata_d[`NCSR_STAT_TRIP_BIT] = (trip_q == ncsr_pkg::NCSR_TRIP_ACTIVE);
        rdata_d[`NCSR_STAT_IN_MSB:`NCSR_STAT_IN_LSB] = stat_q;
      end else if (hit(i_addr, `NCSR_OFS_VALUE)) begin
        rdata_d[VAL_W-1:0] = value;
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_contact_open = open_q;
  assign o_tripped = (trip_q == ncsr_pkg::NCSR_TRIP_ACTIVE);

endmodule

// [pkg/ncsr_pkg.sv]
// Types shared by the status relay block
package ncsr_pkg;

  // Contact behaviour selected by software
  typedef enum logic [3:0] {
    NCSR_MODE_DISABLED = 4'h0,
    NCSR_MODE_STARTED = 4'h1,
    NCSR_MODE_HIGH_TEMP = 4'h2,
    NCSR_MODE_NO_ALERT = 4'h3,
    NCSR_MODE_APPL_PROC = 4'h4,
    NCSR_MODE_CTRL_PROC = 4'h5,
    NCSR_MODE_TEMP_TRIP = 4'h6,
    NCSR_MODE_INPUT_TRIP = 4'h7,
    NCSR_MODE_PURGE = 4'h8
  } ncsr_mode_t;

  // Hysteresis state of the setpoint comparison
  typedef enum logic {
    NCSR_TRIP_IDLE = 1'b0,
    NCSR_TRIP_ACTIVE = 1'b1
  } ncsr_trip_t;

  // Controller and appliance status bits
  typedef struct packed {
    logic purging_local;
    logic proc_ctrl_local;
    logic proc_ctrl_any;
    logic alerts_any;
    logic high_temp_any;
    logic running_any;
  } ncsr_status_t;

endpackage

// [pkg/ncsr_regs.svh]
// Register offsets, field positions, reset values for the status relay block
`ifndef NCSR_REGS_SVH
`define NCSR_REGS_SVH

// Register byte offsets
`define NCSR_OFS_CTRL 8'h00
`define NCSR_OFS_SETPOINT 8'h04
`define NCSR_OFS_DEADBAND 8'h08
`define NCSR_OFS_STATUS 8'h0c
`define NCSR_OFS_VALUE 8'h10

// Control register fields
`define NCSR_CTRL_MODE_LSB 0
`define NCSR_CTRL_MODE_MSB 3

// Status register fields
`define NCSR_STAT_OPEN_BIT 0
`define NCSR_STAT_TRIP_BIT 1
`define NCSR_STAT_IN_LSB 2
`define NCSR_STAT_IN_MSB 7

// Reset values
`define NCSR_RST_MODE 4'h0
`define NCSR_RST_SETPOINT 16'hffff
`define NCSR_RST_DEADBAND 16'h0000

`endif
